// file: pkg/general_output_defs.svh
`ifndef GENERAL_OUTPUT_DEFS_SVH
`define GENERAL_OUTPUT_DEFS_SVH

// ------------------------------------------------------------
// Port addresses
// ------------------------------------------------------------
`define GOC_WRITE_PORT    16'h03c2
`define GOC_READ_PORT     16'h03cc
`define GOC_STATUS_MONO   16'h03ba
`define GOC_STATUS_COLOR  16'h03da
`define GOC_INDEX_MONO    16'h03b4
`define GOC_INDEX_COLOR   16'h03d4
`define GOC_DATA_MONO     16'h03b5
`define GOC_DATA_COLOR    16'h03d5

// ------------------------------------------------------------
// Field positions, reset value, write mask
// ------------------------------------------------------------
`define GOC_VPOL_BIT      7
`define GOC_HPOL_BIT      6
`define GOC_PAGE_BIT      5
`define GOC_CLKSEL_HI     3
`define GOC_CLKSEL_LO     2
`define GOC_MEMEN_BIT     1
`define GOC_COLOR_BIT     0
`define GOC_RESET_VALUE   8'h00
`define GOC_WRITE_MASK    8'hef
`define GOC_POL_RESERVED  2'h0

// ------------------------------------------------------------
// Graphics modes in which page select applies
// ------------------------------------------------------------
`define GOC_MODE_A        8'h06
`define GOC_MODE_B        8'h0d
`define GOC_MODE_C        8'h0e
`define GOC_MODE_D        8'h11
`define GOC_MODE_E        8'h12

`endif

// file: pkg/general_output_pkg.sv
package general_output_pkg;

	typedef enum logic [3:0]
	{
		VCLK_SYNTH0    = 4'h0,
		VCLK_SYNTH1    = 4'h1,
		VCLK_SYNTH2    = 4'h2,
		VCLK_SYNTH3    = 4'h3,
		VCLK_MCLK      = 4'h4,
		VCLK_MCLK_HALF = 4'h5,
		VCLK_FEAT_DAC  = 4'h6,
		VCLK_FEAT_BOTH = 4'h7,
		VCLK_CRYSTAL   = 4'h8
	} vclk_src_t;

endpackage

// file: pkg/clock_sel_if.sv
interface clock_sel_if;
	import general_output_pkg::*;

	logic [1:0] clock_bits;
	logic       hw_config;
	logic       sw_config;
	logic       mclk_source;
	logic       mclk_half;
	logic       half_enable;
	logic       tv_out_en;
	logic       tv_cfg;
	vclk_src_t  source;

	modport selector
	(
		input  clock_bits, hw_config, sw_config, mclk_source,
		input  mclk_half, half_enable, tv_out_en, tv_cfg,
		output source
	);

	modport owner
	(
		output clock_bits, hw_config, sw_config, mclk_source,
		output mclk_half, half_enable, tv_out_en, tv_cfg,
		input  source
	);
endinterface

// file: core/clock_source_select.sv
module clock_source_select
	import general_output_pkg::*;
(
	clock_sel_if.selector cs
);

	// ------------------------------------------------------------
	// Candidate sources
	// ------------------------------------------------------------
	wire       halve_ok;
	wire       tv_crystal;
	wire       cfg_crystal;
	vclk_src_t mclk_pick;
	vclk_src_t feat_pick;
	vclk_src_t synth_pick;

	assign halve_ok   = cs.mclk_half && cs.half_enable;
	assign mclk_pick  = halve_ok ? VCLK_MCLK_HALF : VCLK_MCLK;
	assign tv_crystal = !cs.hw_config && cs.tv_out_en
		&& cs.tv_cfg;
	assign cfg_crystal = cs.hw_config && cs.sw_config;
	assign feat_pick  = cs.clock_bits[1] ? VCLK_FEAT_BOTH
		: VCLK_FEAT_DAC;
	assign synth_pick = vclk_src_t'({2'h0, cs.clock_bits});

	// ------------------------------------------------------------
	// Priority: memory clock, crystal, feature port, synthesizer
	// ------------------------------------------------------------
	assign cs.source = cs.mclk_source ? mclk_pick
		: (tv_crystal || cfg_crystal) ? VCLK_CRYSTAL
		: cs.sw_config ? feat_pick
		: synth_pick;

endmodule

// file: core/general_output_control.sv
// What this block does
// - Vertical polarity 0: sync idles low, pulses high; 1: idles high.
// - Horizontal polarity 0: sync idles low, pulses high; 1: idles high.
// - Panel-type bit with polarity code 00 selects 800x600 LCD panel.
// - Odd/even on: page bit 0 selects odd, 1 selects even locations.
// - Page select only applies in graphics modes 6h, Dh, Eh, 11h, 12h.
// - Page select ignored when graphics chain or chain-four bit set.
// - Clock bits pick synthesizer 0-3; memory clock source picks mclk/half.
// - Software feature config routes feature clock to DAC, or DAC+CRT.
// - TV-out with TV config bit (hw config bit clear), or both config bits, select the crystal pin clock.
// - Display memory enable 0 blocks all host memory responses.
// - Bit 0 picks mono 3Bx or colour 3Dx status/controller decoding.
// - Register written at port 3C2, read back at port 3CC.
module general_output_control
	import general_output_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 8
)
(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [DATA_W-1:0] io_wdata,
	input  wire logic              vsync_raw,
	input  wire logic              hsync_raw,
	input  wire logic              panel_type_bit,
	input  wire logic              seq_odd_even,
	input  wire logic              seq_chain_four,
	input  wire logic              gfx_chain,
	input  wire logic [7:0]        video_mode,
	input  wire logic              hw_config_bit,
	input  wire logic              sw_config_bit,
	input  wire logic              mclk_source_bit,
	input  wire logic              mclk_half_bit,
	input  wire logic              half_enable_bit,
	input  wire logic              tv_out_enable,
	input  wire logic              tv_config_bit,
	input  wire logic              host_mem_req,
	output logic [DATA_W-1:0]      io_rdata,
	output logic                   io_rdata_valid,
	output logic [DATA_W-1:0]      ctrl_value,
	output logic                   vsync_out,
	output logic                   hsync_out,
	output logic                   panel_800x600,
	output logic                   page_odd_only,
	output logic                   page_even_only,
	output vclk_src_t              vclk_source,
	output logic                   mem_respond,
	output logic                   status_port_hit,
	output logic                   crt_index_hit,
	output logic                   crt_data_hit
);

	`include "general_output_defs.svh"

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (DATA_W != 8)
	begin : g_bad_data
		$error("DATA_W must be 8");
	end
	if (ADDR_W != 16)
	begin : g_bad_addr
		$error("ADDR_W must be 16");
	end

	function automatic logic [15:0] pick_port
	(
		input logic [15:0] mono,
		input logic [15:0] color,
		input logic        sel
	);
		return sel ? color : mono;
	endfunction

	// ------------------------------------------------------------
	// Port decode
	// ------------------------------------------------------------
	logic [DATA_W-1:0] ctrl_q;
	logic [DATA_W-1:0] ctrl_d;
	wire               wr_hit;
	wire               rd_hit;
	wire               color_sel;
	wire [15:0]        status_port;
	wire [15:0]        index_port;
	wire [15:0]        data_port;

	assign wr_hit = io_wr && io_addr == `GOC_WRITE_PORT;
	assign rd_hit = io_rd && io_addr == `GOC_READ_PORT;
	assign color_sel = ctrl_q[`GOC_COLOR_BIT];
	assign status_port = pick_port(`GOC_STATUS_MONO, `GOC_STATUS_COLOR,
		color_sel);
	assign index_port = pick_port(`GOC_INDEX_MONO, `GOC_INDEX_COLOR,
		color_sel);
	assign data_port = pick_port(`GOC_DATA_MONO, `GOC_DATA_COLOR,
		color_sel);

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	assign ctrl_d = wr_hit ? (io_wdata & `GOC_WRITE_MASK) : ctrl_q;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ctrl_q <= `GOC_RESET_VALUE;
		else
			ctrl_q <= ctrl_d;
	end

	// ------------------------------------------------------------
	// Derived controls
	// ------------------------------------------------------------
	wire [1:0] pol_code;
	wire       vsync_d;
	wire       hsync_d;
	wire       panel_d;
	wire       mode_ok;
	wire       page_active;
	wire       page_bit;

	assign pol_code = {ctrl_q[`GOC_VPOL_BIT], ctrl_q[`GOC_HPOL_BIT]};
	assign vsync_d = vsync_raw ^ ctrl_q[`GOC_VPOL_BIT];
	assign hsync_d = hsync_raw ^ ctrl_q[`GOC_HPOL_BIT];
	assign panel_d = panel_type_bit
		&& pol_code == `GOC_POL_RESERVED;
	assign mode_ok = video_mode == `GOC_MODE_A
		|| video_mode == `GOC_MODE_B
		|| video_mode == `GOC_MODE_C
		|| video_mode == `GOC_MODE_D
		|| video_mode == `GOC_MODE_E;
	assign page_active = seq_odd_even && mode_ok
		&& !gfx_chain && !seq_chain_four;
	assign page_bit = ctrl_q[`GOC_PAGE_BIT];

	// ------------------------------------------------------------
	// Video clock source
	// ------------------------------------------------------------
	clock_sel_if cs ();

	assign cs.clock_bits  = ctrl_q[`GOC_CLKSEL_HI:`GOC_CLKSEL_LO];
	assign cs.hw_config   = hw_config_bit;
	assign cs.sw_config   = sw_config_bit;
	assign cs.mclk_source = mclk_source_bit;
	assign cs.mclk_half   = mclk_half_bit;
	assign cs.half_enable = half_enable_bit;
	assign cs.tv_out_en   = tv_out_enable;
	assign cs.tv_cfg      = tv_config_bit;

	clock_source_select u_clock_sel
	(
		.cs (cs.selector)
	);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			io_rdata        <= '0;
			io_rdata_valid  <= 1'b0;
			vsync_out       <= 1'b0;
			hsync_out       <= 1'b0;
			panel_800x600   <= 1'b0;
			page_odd_only   <= 1'b0;
			page_even_only  <= 1'b0;
			vclk_source     <= VCLK_SYNTH0;
			mem_respond     <= 1'b0;
			status_port_hit <= 1'b0;
			crt_index_hit   <= 1'b0;
			crt_data_hit    <= 1'b0;
		end
		else
		begin
			io_rdata        <= rd_hit ? ctrl_q : '0;
			io_rdata_valid  <= rd_hit;
			vsync_out       <= vsync_d;
			hsync_out       <= hsync_d;
			panel_800x600   <= panel_d;
			page_odd_only   <= page_active && !page_bit;
			page_even_only  <= page_active && page_bit;
			vclk_source     <= cs.source;
			mem_respond     <= host_mem_req
				&& ctrl_q[`GOC_MEMEN_BIT];
			status_port_hit <= (io_wr || io_rd)
				&& io_addr == status_port;
			crt_index_hit   <= (io_wr || io_rd)
				&& io_addr == index_port;
			crt_data_hit    <= (io_wr || io_rd)
				&& io_addr == data_port;
		end
	end

	assign ctrl_value = ctrl_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_vsync_polarity: assert property (@(posedge mclk)
		disable iff (sys_rst)
		1'b1 |=> vsync_out == ($past(vsync_raw) ^ $past(ctrl_q[7])))
		else $error("vertical sync polarity wrong");

	a_hsync_polarity: assert property (@(posedge mclk)
		disable iff (sys_rst)
		1'b1 |=> hsync_out == ($past(hsync_raw) ^ $past(ctrl_q[6])))
		else $error("horizontal sync polarity wrong");

	a_panel_code: assert property (@(posedge mclk)
		disable iff (sys_rst)
		panel_type_bit && ctrl_q[7:6] == 2'h0 |=> panel_800x600)
		else $error("panel code not flagged");

	a_page_select: assert property (@(posedge mclk)
		disable iff (sys_rst)
		page_active |=> (page_even_only == $past(page_bit))
			&& (page_odd_only != page_even_only))
		else $error("page select wrong");

	a_page_mode: assert property (@(posedge mclk)
		disable iff (sys_rst)
		!mode_ok |=> !page_odd_only && !page_even_only)
		else $error("page select outside listed modes");

	a_page_ignore: assert property (@(posedge mclk)
		disable iff (sys_rst)
		gfx_chain || seq_chain_four |=> !page_odd_only && !page_even_only)
		else $error("page select not ignored");

	a_clock_mclk: assert property (@(posedge mclk)
		disable iff (sys_rst)
		mclk_source_bit |=> vclk_source == ($past(mclk_half_bit)
			&& $past(half_enable_bit) ? VCLK_MCLK_HALF : VCLK_MCLK))
		else $error("memory clock source wrong");

	a_clock_synth: assert property (@(posedge mclk)
		disable iff (sys_rst)
		!mclk_source_bit && !hw_config_bit && !sw_config_bit
			&& !(tv_out_enable && tv_config_bit)
		|=> vclk_source == vclk_src_t'({2'h0, $past(ctrl_q[3:2])}))
		else $error("synthesizer setting wrong");

	a_clock_feature: assert property (@(posedge mclk)
		disable iff (sys_rst)
		sw_config_bit && !hw_config_bit && !mclk_source_bit
			&& !(tv_out_enable && tv_config_bit)
		|=> vclk_source == ($past(ctrl_q[3]) ? VCLK_FEAT_BOTH
			: VCLK_FEAT_DAC))
		else $error("feature clock routing wrong");

	a_clock_crystal: assert property (@(posedge mclk)
		disable iff (sys_rst)
		!mclk_source_bit && (hw_config_bit && sw_config_bit
			|| !hw_config_bit && tv_out_enable && tv_config_bit)
		|=> vclk_source == VCLK_CRYSTAL)
		else $error("crystal clock not chosen");

	a_mem_gate: assert property (@(posedge mclk)
		disable iff (sys_rst)
		1'b1 |=> mem_respond == ($past(host_mem_req) && $past(ctrl_q[1])))
		else $error("memory response gate wrong");

	a_decode_color: assert property (@(posedge mclk)
		disable iff (sys_rst)
		io_rd && io_addr == (ctrl_q[0] ? 16'h03da : 16'h03ba)
		|=> status_port_hit)
		else $error("status port decode wrong");

	a_readback: assert property (@(posedge mclk)
		disable iff (sys_rst)
		wr_hit ##1 rd_hit |=> io_rdata_valid
			&& io_rdata == ($past(io_wdata, 2) & 8'hef))
		else $error("readback mismatch");

	a_write_mask: assert property (@(posedge mclk)
		disable iff (sys_rst)
		wr_hit |=> ctrl_q == ($past(io_wdata) & 8'hef))
		else $error("written value or reserved bit wrong");

	a_reset_clear: assert property (@(posedge mclk)
		disable iff (sys_rst)
		$fell(sys_rst) |-> ctrl_q == 8'h00 && !ctrl_q[4] ##1 !ctrl_q[4])
		else $error("reset or reserved bit wrong");

endmodule

// file: verification/testbench.sv
`include "general_output_defs.svh"
module testbench
	import general_output_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        mclk;
	logic        sys_rst;
	logic [15:0] io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic        vsync_raw;
	logic        hsync_raw;
	logic        panel_type_bit;
	logic        seq_odd_even;
	logic        seq_chain_four;
	logic        gfx_chain;
	logic [7:0]  video_mode;
	logic        hw_config_bit;
	logic        sw_config_bit;
	logic        mclk_source_bit;
	logic        mclk_half_bit;
	logic        half_enable_bit;
	logic        tv_out_enable;
	logic        tv_config_bit;
	logic        host_mem_req;
	logic [7:0]  io_rdata;
	logic        io_rdata_valid;
	logic [7:0]  ctrl_value;
	logic        vsync_out;
	logic        hsync_out;
	logic        panel_800x600;
	logic        page_odd_only;
	logic        page_even_only;
	vclk_src_t   vclk_source;
	logic        mem_respond;
	logic        status_port_hit;
	logic        crt_index_hit;
	logic        crt_data_hit;
	int          fails;
	int          num_checks;
	int          cycles;
	int          started;
	int          m_reg;
	int          e_rd;
	int          e_vld;
	int          e_vs;
	int          e_hs;
	int          e_pnl;
	int          e_odd;
	int          e_even;
	int          e_vclk;
	int          e_mem;
	int          e_st;
	int          e_ix;
	int          e_dt;
	logic [31:0] seed;
	logic [15:0] addrs [8];
	logic [7:0]  modes [5];

	general_output_control dut (.*);

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// ------------------------------------------------------------
	// Reference model, one cycle behind its inputs
	// ------------------------------------------------------------
	always @(posedge mclk)
	begin
		int act;
		int any;
		cycles++;
		started = 1;
		any = io_wr | io_rd;
		act = seq_odd_even && !gfx_chain && !seq_chain_four &&
			(video_mode inside {8'h06, 8'h0d, 8'h0e, 8'h11, 8'h12});
		e_rd = (io_rd && io_addr == `GOC_READ_PORT) ? m_reg : 0;
		e_vld = io_rd && io_addr == `GOC_READ_PORT;
		e_vs = vsync_raw ^ m_reg[7];
		e_hs = hsync_raw ^ m_reg[6];
		e_pnl = panel_type_bit && m_reg[7:6] == 0;
		e_odd = act && !m_reg[5];
		e_even = act && m_reg[5];
		if (mclk_source_bit)
			e_vclk = (mclk_half_bit && half_enable_bit) ? 5 : 4;
		else if ((tv_out_enable && tv_config_bit && !hw_config_bit) ||
			(hw_config_bit && sw_config_bit))
			e_vclk = 8;
		else if (sw_config_bit)
			e_vclk = m_reg[3] ? 7 : 6;
		else
			e_vclk = m_reg[3:2];
		e_mem = host_mem_req && m_reg[1];
		e_st = any && io_addr == (m_reg[0] ? 16'h03da : 16'h03ba);
		e_ix = any && io_addr == (m_reg[0] ? 16'h03d4 : 16'h03b4);
		e_dt = any && io_addr == (m_reg[0] ? 16'h03d5 : 16'h03b5);
		if (io_wr && io_addr == `GOC_WRITE_PORT)
			m_reg = io_wdata & 8'hef;
		if (sys_rst)
			{m_reg, e_rd, e_vld, e_vs, e_hs, e_pnl, e_odd, e_even} = '0;
		if (sys_rst)
			{e_vclk, e_mem, e_st, e_ix, e_dt} = '0;
		if (cycles >= 8000)
		begin
			fails++;
			give_verdict();
		end
	end

	task check(input string name, input int exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== 8'(exp))
		begin
			fails++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	always @(negedge mclk)
	begin
		if (started)
		begin
			check("ctrl_value", m_reg, ctrl_value);
			check("io_rdata", e_rd, io_rdata);
			check("io_rdata_valid", e_vld, 8'(io_rdata_valid));
			check("vsync_out", e_vs, 8'(vsync_out));
			check("hsync_out", e_hs, 8'(hsync_out));
			check("panel_800x600", e_pnl, 8'(panel_800x600));
			check("page_odd_only", e_odd, 8'(page_odd_only));
			check("page_even_only", e_even, 8'(page_even_only));
			check("vclk_source", e_vclk, 8'(vclk_source));
			check("mem_respond", e_mem, 8'(mem_respond));
			check("status_port_hit", e_st, 8'(status_port_hit));
			check("crt_index_hit", e_ix, 8'(crt_index_hit));
			check("crt_data_hit", e_dt, 8'(crt_data_hit));
		end
	end

	// ------------------------------------------------------------
	// Drivers, all changes at the falling edge
	// ------------------------------------------------------------
	task acc(input logic wr, input logic rd, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge mclk);
		io_wr = wr;
		io_rd = rd;
		io_addr = a;
		io_wdata = d;
	endtask

	task drive_random();
		logic [31:0] r;
		logic [31:0] s;
		r = rnd();
		s = rnd();
		@(negedge mclk);
		io_addr = (r[3] & r[4]) ? s[31:16] : addrs[r[2:0]];
		io_wr = r[6:5] == 2'h0;
		io_rd = r[6:5] == 2'h1;
		io_wdata = r[15:8];
		{vsync_raw, hsync_raw, panel_type_bit, seq_odd_even} = s[7:4];
		{seq_chain_four, gfx_chain, hw_config_bit, sw_config_bit} = r[19:16];
		{mclk_source_bit, mclk_half_bit, half_enable_bit} = r[22:20];
		{tv_out_enable, tv_config_bit, host_mem_req} = r[25:23];
		video_mode = s[3] ? modes[s[2:0] % 5] : s[15:8];
	endtask

	task do_reset(input int n);
		@(negedge mclk);
		sys_rst = 1'b1;
		repeat (n) @(negedge mclk);
		sys_rst = 1'b0;
		$display("reset test done");
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		seed = 32'h320e;
		addrs = '{16'h03c2, 16'h03cc, 16'h03ba, 16'h03da,
			16'h03b4, 16'h03d4, 16'h03b5, 16'h03d5};
		modes = '{8'h06, 8'h0d, 8'h0e, 8'h11, 8'h12};
		{fails, num_checks, cycles, started, m_reg} = '0;
		{io_addr, io_wr, io_rd, io_wdata, video_mode} = '0;
		{vsync_raw, hsync_raw, panel_type_bit, seq_odd_even} = '0;
		{seq_chain_four, gfx_chain, hw_config_bit, sw_config_bit} = '0;
		{mclk_source_bit, mclk_half_bit, half_enable_bit} = '0;
		{tv_out_enable, tv_config_bit, host_mem_req} = '0;
		sys_rst = 1'b1;
		repeat (3) @(posedge mclk);
		do_reset(1);
		acc(1'b1, 1'b0, `GOC_WRITE_PORT, 8'hff);
		acc(1'b0, 1'b1, `GOC_READ_PORT, 8'h00);
		acc(1'b1, 1'b0, `GOC_READ_PORT, 8'h00);
		acc(1'b0, 1'b1, `GOC_WRITE_PORT, 8'h00);
		for (int k = 0; k < 4; k++)
			acc(1'b1, 1'b0, `GOC_WRITE_PORT, 8'(k * 4 + 1));
		for (int k = 1; k < 4; k++)
			acc(1'b1, 1'b0, `GOC_WRITE_PORT, 8'(k << 6));
		acc(1'b0, 1'b1, `GOC_READ_PORT, 8'h00);
		acc(1'b0, 1'b0, 16'h0000, 8'h00);
		$display("directed test done");
		repeat (4000) drive_random();
		$display("random test done");
		do_reset(2);
		repeat (1000) drive_random();
		$display("random after reset test done");
		repeat (3) @(negedge mclk);
		give_verdict();
	end
endmodule
